// File: dbt_evt_src.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Event source standing in for the routing network.
module dbt_evt_src (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       go,
    input  wire logic [7:0] n,
    output logic            busy,
    output logic            evt_in
);
    logic [7:0] left_reg;
    logic [1:0] gap_reg;
    // Toggles the line n times, four clocks apart, well below the count rate.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            left_reg <= 8'h00;
            gap_reg  <= 2'h0;
            evt_in   <= 1'b0;
        end else if (go) begin
            left_reg <= n;
        end else if (left_reg != 8'h00) begin
            gap_reg <= gap_reg + 2'h1;
            if (gap_reg == 2'h3) begin
                evt_in   <= ~evt_in;
                left_reg <= left_reg - 8'h01;
            end
        end
    end
    // Busy while toggles remain.
    assign busy = (left_reg != 8'h00);
endmodule
`default_nettype wire

// File: dbt_pkg.sv
// Behaviour
// RQ1: Dual-byte mode runs low and high byte counters independently, both counting down.
// RQ2: Dual-byte mode supports only single-slope PWM via the waveform mode field.
// RQ3: High byte counter has its own underflow flag; low byte flags act as normal.
// RQ4: High byte compare matches set no flag and raise no interrupt.
// RQ5: Event inputs are ignored in dual-byte mode.
// RQ6: Buffered period and compare registers have no effect in dual-byte mode.
// RQ7: All registers are single-byte accessible in dual-byte mode, no temp pairing.
// RQ8: Mode switch changes register meaning but keeps stored values.
// RQ9: Software sets dual-byte select, writes periods, then enables the timer.
// RQ10: One-cycle event on wrap in normal mode, low underflow in dual-byte mode.
// RQ11: One-cycle event on high byte underflow, only in dual-byte mode.
// RQ12: One-cycle compare event per channel: 16-bit match normal, low byte match dual.
// RQ13: Each event fires exactly when its interrupt flag is set.
// RQ14: Event input counts on rising edge, any edge, high level, or sets direction.
// RQ15: Event source toggles slower than counting rate for level actions.
// RQ16: Event action comes from action field, used only while count-on-event enabled.
// RQ17: Normal mode sets the wrap flag at top or bottom.
// RQ18: Normal mode sets compare flag n when counter equals compare n.
// RQ19: Dual-byte mode sets low and high underflow flags at each counter bottom.
// RQ20: Dual-byte mode sets compare flag n on low counter equal low compare byte.
// RQ21: Interrupt request is high while flag and enable are both set.
// RQ22: Timer keeps running in idle sleep.
// RQ23: Dual-byte waveform outputs go low at bottom and high on match.
// RQ24: Hard reset command restores all registers, accepted only while disabled.
// RQ25: Writing one to a flag bit clears it; writing zero leaves it.
package dbt_pkg;
    // ==========================================================
    // Register offsets (word index = byte offset / 4 not needed: offsets are byte indexes).
    localparam logic [5:0] OFS_MAIN_CTRL  = 6'h00;
    localparam logic [5:0] OFS_WAVE_CTRL  = 6'h01;
    localparam logic [5:0] OFS_MODE_CTRL  = 6'h03;
    localparam logic [5:0] OFS_CMD_CLR    = 6'h04;
    localparam logic [5:0] OFS_CMD_SET    = 6'h05;
    localparam logic [5:0] OFS_EVT_CTRL   = 6'h09;
    localparam logic [5:0] OFS_IRQ_EN     = 6'h0A;
    localparam logic [5:0] OFS_IRQ_FLAG   = 6'h0B;
    localparam logic [5:0] OFS_TEMP       = 6'h0F;
    localparam logic [5:0] OFS_CNT_LO     = 6'h20;
    localparam logic [5:0] OFS_CNT_HI     = 6'h21;
    localparam logic [5:0] OFS_PER_LO     = 6'h26;
    localparam logic [5:0] OFS_PER_HI     = 6'h27;
    localparam logic [5:0] OFS_CMP_BASE   = 6'h28;
    localparam logic [5:0] OFS_PBUF_LO    = 6'h36;
    localparam logic [5:0] OFS_PBUF_HI    = 6'h3D;
    localparam logic [5:0] OFS_BV_CLR     = 6'h06;
    localparam logic [5:0] OFS_BV_SET     = 6'h07;
    // ==========================================================
    // Field positions and values.
    localparam int        BIT_ENABLE     = 0;
    localparam int        BIT_DUAL       = 0;
    localparam int        BIT_CNT_ON_EVT = 0;
    localparam int        BIT_DIR        = 0;
    localparam int        BIT_WRAP       = 0;
    localparam int        BIT_HI_UNF     = 1;
    localparam int        BIT_CMP_ZERO   = 4;
    localparam logic [2:0] WG_ONE_SLOPE  = 3'h3;
    localparam logic [1:0] CMD_HARD_RST  = 2'h3;
    localparam logic [7:0] RST_VAL       = 8'h00;
    localparam logic [15:0] PER_RST_VAL  = 16'hFFFF;
    localparam int        SYNC_STAGES    = 3;
    // ==========================================================
    // Event action codes.
    typedef enum logic [2:0] {
        EVA_RISE  = 3'h0,
        EVA_ANY   = 3'h1,
        EVA_HIGH  = 3'h2,
        EVA_DIR   = 3'h3
    } dbt_evt_action_t;
    // Avalon-MM slave request carrier.
    typedef struct packed {
        logic       read;
        logic       write;
        logic [5:0] address;
        logic [7:0] writedata;
    } dbt_bus_req_t;
    // Event outputs: wrap or low underflow, high underflow, three compare matches.
    typedef struct packed {
        logic       wrap_or_low_underflow_event;
        logic       high_byte_underflow;
        logic [2:0] compare_match;
    } dbt_events_t;
endpackage

// File: dbt_timer.sv
`timescale 1ns/1ps
`default_nettype none
module dbt_timer
    import dbt_pkg::*;
#(
    parameter int NCH = 3
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire dbt_bus_req_t avs_req,
    output logic [7:0]        avs_readdata,
    output logic              avs_waitrequest,
    input  wire logic         evt_in,
    output dbt_events_t       evt_out,
    output logic              irq,
    output logic [2*NCH-1:0]  wave_out
);
    // ==========================================================
    // Registers.
    logic [7:0]        main_control_reg;
    logic [7:0]        wave_ctrl_reg;
    logic [7:0]        mode_control_reg;
    logic [7:0]        evt_ctrl_reg;
    logic [7:0]        irq_enable_reg;
    logic [7:0]        irq_flag_reg;
    logic [7:0]        dir_reg;
    logic [7:0]        temp_reg;
    logic [15:0]       cnt_reg;
    logic [15:0]       per_reg;
    logic [15:0]       cmp_reg [NCH];
    logic [7:0]        pbuf_reg [8];
    logic [3:0]        bv_reg;
    logic [9:0]        presc_reg;
    logic [2*NCH-1:0]  wave_reg;
    logic [SYNC_STAGES-1:0] sync_reg;
    logic              ack_reg;
    dbt_events_t       evt_reg;

    logic        dual;
    logic        enabled;
    logic        tick;
    logic        step;
    logic        down;
    logic        wr;
    logic        rd;
    logic [5:0]  a;
    logic [7:0]  wd;
    logic        hard_rst;
    logic        ev_rise;
    logic        ev_fall;
    logic        ev_lvl;
    logic        lo_unf;
    logic        hi_unf;
    logic        wrap_hit;
    logic [2:0]  cmp_hit;
    logic [7:0]  flag_set;
    logic [2:0]  dbt_clk_sel;
    logic [9:0]  presc_mask;

    assign a       = avs_req.address;
    assign wd      = avs_req.writedata;
    assign dual    = mode_control_reg[BIT_DUAL];
    assign enabled = main_control_reg[BIT_ENABLE];
    assign dbt_clk_sel = main_control_reg[3:1];

    // Bus answers in the cycle after the request is seen; writes happen on that acknowledge edge.
    assign avs_waitrequest = (avs_req.read | avs_req.write) & ~ack_reg;
    assign wr = avs_req.write & ack_reg;
    assign rd = avs_req.read & ack_reg;
    assign hard_rst = wr && a == OFS_CMD_SET && wd[3:2] == CMD_HARD_RST && !enabled; // RQ24

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_req.read | avs_req.write) & ~ack_reg;
        end
    end

    // ==========================================================
    // Event input synchroniser; edges seen once stages two and three agree.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= {sync_reg[SYNC_STAGES-2:0], evt_in};
        end
    end
    assign ev_lvl  = sync_reg[1] & sync_reg[2];
    logic ev_prev_reg;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ev_prev_reg <= 1'b0;
        end else if (sync_reg[1] == sync_reg[2]) begin
            ev_prev_reg <= sync_reg[2];
        end
    end
    assign ev_rise = (sync_reg[1] == sync_reg[2]) &  sync_reg[2] & ~ev_prev_reg;
    assign ev_fall = (sync_reg[1] == sync_reg[2]) & ~sync_reg[2] &  ev_prev_reg;

    // ==========================================================
    // Prescaler; keeps running in idle sleep since only the enable bit gates it.
    always_comb begin
        unique case (dbt_clk_sel)
            3'h0: presc_mask = 10'h000;
            3'h1: presc_mask = 10'h001;
            3'h2: presc_mask = 10'h003;
            3'h3: presc_mask = 10'h007;
            3'h4: presc_mask = 10'h00F;
            3'h5: presc_mask = 10'h03F;
            3'h6: presc_mask = 10'h0FF;
            3'h7: presc_mask = 10'h3FF;
        endcase
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_reg <= '0;
        end else if (!enabled) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_reg + 10'h001; // RQ22
        end
    end
    assign tick = enabled && ((presc_reg & presc_mask) == presc_mask);

    // Counting step: event actions apply only in normal mode with count-on-event enabled.
    always_comb begin
        step = tick;
        down = dir_reg[BIT_DIR];
        if (!dual && evt_ctrl_reg[BIT_CNT_ON_EVT]) begin // RQ5 RQ16
            unique case (evt_ctrl_reg[3:1])
                EVA_RISE: step = enabled && ev_rise; // RQ14
                EVA_ANY:  step = enabled && (ev_rise || ev_fall);
                EVA_HIGH: step = tick && ev_lvl;
                EVA_DIR:  down = ev_lvl;
                default:  step = tick;
            endcase
        end
    end

    // ==========================================================
    // Match and wrap conditions; each also drives its event output.
    assign lo_unf   = dual && step && cnt_reg[7:0] == 8'h00; // RQ19
    assign hi_unf   = dual && step && cnt_reg[15:8] == 8'h00; // RQ3 RQ11
    assign wrap_hit = !dual && step && (down ? cnt_reg == 16'h0000 : cnt_reg == per_reg); // RQ17
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            cmp_hit[i] = dual ? (step && cnt_reg[7:0] == cmp_reg[i][7:0]) // RQ20 RQ4
                              : (step && cnt_reg == cmp_reg[i]); // RQ18
        end
    end
    always_comb begin
        flag_set = 8'h00;
        flag_set[BIT_WRAP] = wrap_hit | lo_unf;
        flag_set[BIT_HI_UNF] = hi_unf;
        flag_set[BIT_CMP_ZERO +: 3] = cmp_hit;
    end

    // Event pulses are one cycle, registered from the same condition as the flags.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_reg <= '0;
        end else begin
            evt_reg.wrap_or_low_underflow_event <= wrap_hit | lo_unf; // RQ10 RQ13
            evt_reg.high_byte_underflow         <= hi_unf; // RQ11
            evt_reg.compare_match               <= cmp_hit; // RQ12
        end
    end
    assign evt_out = evt_reg;

    // ==========================================================
    // Counter: one 16-bit counter normally, two independent down counters in dual mode.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 16'h0000;
        end else if (hard_rst) begin
            cnt_reg <= 16'h0000;
        end else if (wr && a == OFS_CNT_LO) begin
            cnt_reg[7:0] <= wd; // RQ7
        end else if (wr && a == OFS_CNT_HI) begin
            if (dual) cnt_reg[15:8] <= wd;
            else      cnt_reg       <= {wd, temp_reg};
        end else if (step && dual) begin
            cnt_reg[7:0]  <= lo_unf ? per_reg[7:0]  : cnt_reg[7:0]  - 8'h01; // RQ1
            cnt_reg[15:8] <= hi_unf ? per_reg[15:8] : cnt_reg[15:8] - 8'h01;
        end else if (step) begin
            if (down) cnt_reg <= (cnt_reg == 16'h0000) ? per_reg : cnt_reg - 16'h0001;
            else      cnt_reg <= (cnt_reg >= per_reg) ? 16'h0000 : cnt_reg + 16'h0001;
        end
    end

    // Waveform outputs: low at bottom, high on match, one per byte channel.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wave_reg <= '0;
        end else if (hard_rst) begin
            wave_reg <= '0;
        end else if (dual && wave_ctrl_reg[2:0] == WG_ONE_SLOPE && step) begin // RQ2
            for (int i = 0; i < NCH; i++) begin
                if (cnt_reg[7:0] == cmp_reg[i][7:0])        wave_reg[i] <= 1'b1; // RQ23
                else if (cnt_reg[7:0] == 8'h00)             wave_reg[i] <= 1'b0;
                if (cnt_reg[15:8] == cmp_reg[i][15:8])      wave_reg[NCH+i] <= 1'b1;
                else if (cnt_reg[15:8] == 8'h00)            wave_reg[NCH+i] <= 1'b0;
            end
        end
    end
    assign wave_out = wave_reg;

    // ==========================================================
    // Control registers; values survive a mode switch, only reset and hard reset clear them.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            main_control_reg <= RST_VAL;
            wave_ctrl_reg    <= RST_VAL;
            mode_control_reg <= RST_VAL;
            evt_ctrl_reg     <= RST_VAL;
            irq_enable_reg   <= RST_VAL;
            dir_reg          <= RST_VAL;
        end else if (hard_rst) begin // RQ24
            main_control_reg <= RST_VAL;
            wave_ctrl_reg    <= RST_VAL;
            mode_control_reg <= RST_VAL;
            evt_ctrl_reg     <= RST_VAL;
            irq_enable_reg   <= RST_VAL;
            dir_reg          <= RST_VAL;
        end else if (wr) begin
            if (a == OFS_MAIN_CTRL) main_control_reg <= {4'h0, wd[3:0]};
            if (a == OFS_WAVE_CTRL) wave_ctrl_reg    <= {1'b0, wd[6:0]};
            if (a == OFS_MODE_CTRL) mode_control_reg <= {7'h00, wd[0]}; // RQ8 RQ9
            if (a == OFS_EVT_CTRL)  evt_ctrl_reg     <= {4'h0, wd[3:0]};
            if (a == OFS_IRQ_EN)    irq_enable_reg   <= {1'b0, wd[6:4], 2'b00, wd[1:0]};
            if (a == OFS_CMD_SET && wd[BIT_DIR]) dir_reg[BIT_DIR] <= 1'b1;
            if (a == OFS_CMD_CLR && wd[BIT_DIR]) dir_reg[BIT_DIR] <= 1'b0;
        end
    end

    // Period, compare, buffer and temp registers; buffers are stored but never used.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            per_reg  <= PER_RST_VAL;
            temp_reg <= RST_VAL;
            bv_reg   <= 4'h0;
            for (int i = 0; i < NCH; i++) cmp_reg[i] <= 16'h0000;
            for (int i = 0; i < 8; i++)   pbuf_reg[i] <= RST_VAL;
        end else if (hard_rst) begin
            per_reg  <= PER_RST_VAL;
            temp_reg <= RST_VAL;
            bv_reg   <= 4'h0;
            for (int i = 0; i < NCH; i++) cmp_reg[i] <= 16'h0000;
            for (int i = 0; i < 8; i++)   pbuf_reg[i] <= RST_VAL;
        end else if (wr) begin
            if (!dual && (a == OFS_PER_LO || a == OFS_CNT_LO || (a >= OFS_CMP_BASE && !a[0])))
                temp_reg <= wd; // RQ7
            if (a == OFS_PER_LO) per_reg[7:0] <= wd;
            if (a == OFS_PER_HI) begin
                if (dual) per_reg[15:8] <= wd;
                else      per_reg       <= {wd, temp_reg};
            end
            for (int i = 0; i < NCH; i++) begin
                if (a == OFS_CMP_BASE + 6'(2*i)) cmp_reg[i][7:0] <= wd;
                if (a == OFS_CMP_BASE + 6'(2*i+1)) begin
                    if (dual) cmp_reg[i][15:8] <= wd;
                    else      cmp_reg[i]       <= {wd, temp_reg};
                end
            end
            if (a >= OFS_PBUF_LO && a <= OFS_PBUF_HI) pbuf_reg[3'(a - OFS_PBUF_LO)] <= wd; // RQ6
            if (a == OFS_BV_SET) bv_reg <= bv_reg | wd[3:0];
            if (a == OFS_BV_CLR) bv_reg <= bv_reg & ~wd[3:0];
        end
    end

    // Interrupt flags: hardware set wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_flag_reg <= RST_VAL;
        end else if (hard_rst) begin
            irq_flag_reg <= RST_VAL;
        end else begin
            irq_flag_reg <= ((wr && a == OFS_IRQ_FLAG) ? (irq_flag_reg & ~wd) : irq_flag_reg) // RQ25
                            | flag_set; // RQ21
        end
    end
    assign irq = |(irq_flag_reg & irq_enable_reg); // RQ21

    // ==========================================================
    // Read data, registered at the edge the request is first seen, one edge before acknowledge; unmapped reads give zero.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 8'h00;
        end else if (avs_req.read && !ack_reg) begin
            avs_readdata <= 8'h00;
            unique case (a)
                OFS_MAIN_CTRL: avs_readdata <= main_control_reg;
                OFS_WAVE_CTRL: avs_readdata <= wave_ctrl_reg;
                OFS_MODE_CTRL: avs_readdata <= mode_control_reg;
                OFS_CMD_CLR, OFS_CMD_SET: avs_readdata <= dir_reg;
                OFS_BV_CLR, OFS_BV_SET:   avs_readdata <= {4'h0, bv_reg};
                OFS_EVT_CTRL:  avs_readdata <= evt_ctrl_reg;
                OFS_IRQ_EN:    avs_readdata <= irq_enable_reg;
                OFS_IRQ_FLAG:  avs_readdata <= irq_flag_reg;
                OFS_TEMP:      avs_readdata <= temp_reg;
                OFS_CNT_LO:    avs_readdata <= cnt_reg[7:0];
                OFS_CNT_HI:    avs_readdata <= cnt_reg[15:8];
                OFS_PER_LO:    avs_readdata <= per_reg[7:0];
                OFS_PER_HI:    avs_readdata <= per_reg[15:8];
                OFS_CMP_BASE:        avs_readdata <= cmp_reg[0][7:0];
                OFS_CMP_BASE + 6'h1: avs_readdata <= cmp_reg[0][15:8];
                OFS_CMP_BASE + 6'h2: avs_readdata <= cmp_reg[1][7:0];
                OFS_CMP_BASE + 6'h3: avs_readdata <= cmp_reg[1][15:8];
                OFS_CMP_BASE + 6'h4: avs_readdata <= cmp_reg[2][7:0];
                OFS_CMP_BASE + 6'h5: avs_readdata <= cmp_reg[2][15:8];
                default:       avs_readdata <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Checks.
    sequence s_low_bottom;
        dual && step && cnt_reg[7:0] == 8'h00;
    endsequence
    property p_low_unf_flag;
        @(posedge ref_clk) disable iff (!rst_n) s_low_bottom |=> irq_flag_reg[BIT_WRAP] && evt_out.wrap_or_low_underflow_event;
    endproperty
    a_low_unf_flag: assert property (p_low_unf_flag) else $error("low underflow flag or event missing"); // RQ19
    property p_hi_unf_normal;
        @(posedge ref_clk) disable iff (!rst_n) !$past(dual) |-> !evt_out.high_byte_underflow;
    endproperty
    a_hi_unf_normal: assert property (p_hi_unf_normal) else $error("high underflow event in normal mode"); // RQ11
    property p_pulse_one;
        @(posedge ref_clk) disable iff (!rst_n)
            (evt_out.high_byte_underflow && per_reg[15:8] != 8'h00 && !wr) |=> !evt_out.high_byte_underflow;
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("event pulse too long"); // RQ11
    property p_irq_level;
        @(posedge ref_clk) disable iff (!rst_n)
            (irq && !hard_rst && !(wr && (a == OFS_IRQ_FLAG || a == OFS_IRQ_EN))) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq missing while flag enabled"); // RQ21
    property p_cmp_event;
        @(posedge ref_clk) disable iff (!rst_n) cmp_hit[0] |=> evt_out.compare_match[0] && irq_flag_reg[BIT_CMP_ZERO];
    endproperty
    a_cmp_event: assert property (p_cmp_event) else $error("compare event and flag disagree"); // RQ13
    property p_dual_down;
        @(posedge ref_clk) disable iff (!rst_n) (dual && step && cnt_reg[7:0] != 8'h00 && !wr && !hard_rst) |=> cnt_reg[7:0] == $past(cnt_reg[7:0]) - 8'h01;
    endproperty
    a_dual_down: assert property (p_dual_down) else $error("low byte counter did not count down"); // RQ1
    property p_hard_rst_gate;
        @(posedge ref_clk) disable iff (!rst_n) (wr && a == OFS_CMD_SET && wd[3:2] == CMD_HARD_RST && enabled) |=> main_control_reg[BIT_ENABLE];
    endproperty
    a_hard_rst_gate: assert property (p_hard_rst_gate) else $error("hard reset accepted while enabled"); // RQ24
    property p_flag_clear;
        @(posedge ref_clk) disable iff (!rst_n)
            (wr && a == OFS_IRQ_FLAG && wd[BIT_HI_UNF] && !hi_unf && !hard_rst) |=> !irq_flag_reg[BIT_HI_UNF];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by write one"); // RQ25
endmodule
`default_nettype wire

// File: tb_dual_byte_timer_events_irq.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench for the dual-byte timer.
module tb_dual_byte_timer_events_irq
    import dbt_pkg::*;
;
    typedef struct packed {logic w; logic [5:0] a; logic [7:0] d; logic [1:0] ic;} dbt_row_t;
    localparam logic       W = 1'b1, R = 1'b0;
    localparam logic [1:0] N = 2'h0, I0 = 2'h2, I1 = 2'h3;
    logic         ref_clk, rst_n, evt_in, irq, go, busy, avs_waitrequest, cnt_on;
    logic [7:0]   avs_readdata, n, rd;
    logic [5:0]   wave_out;
    dbt_bus_req_t avs_req;
    dbt_events_t  evt_out;
    int           fail_count, comparisons, lo_n, hi_n, c0_n, c1_n, c2_n, w0_n, w3_n;
    // Each row is one bus access, read rows carry the expected data.
    dbt_row_t     rows [42] = '{
        {R,6'h00,8'h00,N}, {R,6'h26,8'hFF,N}, {R,6'h27,8'hFF,N}, {R,6'h0B,8'h00,N},
        {R,6'h08,8'h00,N}, {W,6'h08,8'h5A,N}, {R,6'h08,8'h00,N}, {W,6'h03,8'h01,N},
        {W,6'h26,8'h03,N}, {R,6'h26,8'h03,N}, {W,6'h27,8'h05,N}, {W,6'h28,8'h01,N},
        {W,6'h29,8'h02,N}, {W,6'h2A,8'h09,N}, {W,6'h0A,8'h33,N}, {W,6'h09,8'h01,N},
        {W,6'h00,8'h00,N}, {R,6'h0B,8'h53,I1}, {W,6'h0A,8'h00,I0}, {W,6'h0A,8'h33,I1},
        {W,6'h0B,8'h01,I1}, {R,6'h0B,8'h52,N}, {W,6'h0B,8'h52,I0}, {R,6'h0B,8'h00,N},
        {W,6'h03,8'h00,N}, {R,6'h26,8'h03,N}, {W,6'h00,8'h01,N}, {W,6'h05,8'h0C,N},
        {R,6'h26,8'h03,N}, {W,6'h00,8'h00,N}, {W,6'h05,8'h0C,N}, {R,6'h26,8'hFF,N},
        {R,6'h03,8'h00,N}, {W,6'h26,8'h40,N}, {W,6'h27,8'h00,N}, {W,6'h09,8'h01,N},
        {W,6'h00,8'h01,N}, {R,6'h20,8'h05,N}, {W,6'h09,8'h03,N}, {R,6'h20,8'h0B,N},
        {W,6'h09,8'h05,N}, {R,6'h20,8'h0B,N}};

    dbt_timer #(.NCH(3)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .avs_req(avs_req),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .evt_in(evt_in),
        .evt_out(evt_out), .irq(irq), .wave_out(wave_out));
    dbt_evt_src u_src (.ref_clk(ref_clk), .rst_n(rst_n), .go(go), .n(n), .busy(busy), .evt_in(evt_in));

    // ==========================================================
    // Tasks.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // Holds the request until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        avs_req <= '{read: !w, write: w, address: a, writedata: d};
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        rd = avs_readdata;
        avs_req <= '0;
    endtask
    task automatic run_rows(input int lo, input int hi);
        for (int i = lo; i <= hi; i++) begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) check(rd, rows[i].d);
            if (rows[i].ic[1]) begin
                repeat (2) @(negedge ref_clk);
                check({7'h00, irq}, {7'h00, rows[i].ic[0]});
            end
        end
    endtask
    // Waits for the source to idle, then orders k toggles.
    task automatic pulse(input logic [7:0] k);
        @(posedge ref_clk);
        while (busy === 1'b1) @(posedge ref_clk);
        go <= 1'b1;
        n  <= k;
        @(posedge ref_clk);
        go <= 1'b0;
    endtask
    task automatic finish_test;
        if (fail_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ==========================================================
    // Clock, counters and watchdog.
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Counts event pulse cycles and waveform high time within the window.
    always @(negedge ref_clk) begin
        if (cnt_on) begin
            lo_n += int'(evt_out.wrap_or_low_underflow_event);
            hi_n += int'(evt_out.high_byte_underflow);
            c0_n += int'(evt_out.compare_match[0]);
            c1_n += int'(evt_out.compare_match[1]);
            c2_n += int'(evt_out.compare_match[2]);
            w0_n += int'(wave_out[0]);
            w3_n += int'(wave_out[3]);
        end
    end
    initial begin
        #1000000;
        fail_count++;
        finish_test();
    end
    // Main sequence: dual-byte run, flags, mode change, event counting.
    initial begin
        {rst_n, go, n, cnt_on, avs_req} = '0;
        {fail_count, comparisons, lo_n, hi_n, c0_n, c1_n, c2_n, w0_n, w3_n} = '0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        run_rows(0, 15);
        bus(W, OFS_WAVE_CTRL, 8'h03);
        bus(W, OFS_MAIN_CTRL, 8'h01);
        pulse(8'd24);
        repeat (10) @(posedge ref_clk);
        cnt_on <= 1'b1;
        repeat (48) @(posedge ref_clk);
        cnt_on <= 1'b0;
        check(8'(lo_n), 8'd12);
        check(8'(hi_n), 8'd8);
        check(8'(c0_n), 8'd12);
        check(8'(c1_n), 8'd0);
        check(8'(w0_n), 8'd12);
        check(8'(c2_n), 8'd12);
        check(8'(w3_n), 8'd16);
        run_rows(16, 36);
        pulse(8'd10);
        pulse(8'd0);
        repeat (8) @(posedge ref_clk);
        run_rows(37, 38);
        pulse(8'd6);
        pulse(8'd0);
        repeat (8) @(posedge ref_clk);
        run_rows(39, 41);
        // A six-cycle high level steps the counter five times once it has passed the synchroniser.
        pulse(8'd1);
        pulse(8'd1);
        repeat (8) @(posedge ref_clk);
        bus(R, OFS_CNT_LO, 8'h00);
        check(rd, 8'h10);
        finish_test();
    end
endmodule
`default_nettype wire
